/* common/ccd_pkg.sv */
package ccd_pkg;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int PC_W   = 15;
  localparam int INS_W  = 14;
  localparam int LATH_W = 7;

  // fixed opcodes of this slice
  localparam logic [13:0] WATCHDOG_CLEAR_CODE = 14'h0064;
  localparam logic [13:0] COMPUTED_CALL_CODE  = 14'h000a;
  localparam logic [5:0]  INVERT_FILE_CODE    = 6'h09;
  localparam logic [5:0]  FILE_DECREMENT_CODE = 6'h03;
  localparam logic [5:0]  DECREMENT_SKIP_CODE = 6'h0b;
  localparam logic [6:0]  ZERO_FILE_CODE      = 7'h03;
  localparam logic [6:0]  ZERO_ACCUM_CODE     = 7'h02;
  localparam int          DEST_BIT            = 7;

  localparam logic [7:0]  BYTE_ZERO  = 8'h00;
  localparam logic [7:0]  BYTE_ONE   = 8'h01;
  localparam logic [7:0]  BYTE_MAX   = 8'hff;
  localparam logic [14:0] PC_ZERO    = 15'h0000;
  localparam logic [14:0] PC_ONE     = 15'h0001;
  localparam logic [6:0]  ADDR_ZERO  = 7'h00;
  localparam logic        DEST_ACCUM = 1'b0;

  // flag values after reset
  localparam logic EXPIRY_RST = 1'b1;
  localparam logic PDOWN_RST  = 1'b1;

  typedef enum logic [2:0] {
    OP_NONE, OP_WATCHDOG_CLEAR, OP_COMPUTED_CALL, OP_INVERT_FILE,
    OP_ZERO_FILE, OP_ZERO_ACCUM, OP_FILE_DECREMENT, OP_DECREMENT_SKIP
  } ccd_op_t;

  typedef enum logic [1:0] {ST_IDLE, ST_CALL_LOAD, ST_SKIP_NOP} ccd_state_t;
endpackage

/* rtl/ccd_opdec.sv */
module ccd_opdec
  import ccd_pkg::*;
(
  input  wire logic [13:0] instr_in,  // instruction word
  output ccd_op_t          op_out,    // decoded operation
  output logic             dest_out,  // destination select
  output logic [6:0]       addr_out   // file operand address
);
  always_comb begin
    dest_out = instr_in[DEST_BIT];
    addr_out = instr_in[ADDR_W-1:0];
    op_out   = OP_NONE;
    if (instr_in == WATCHDOG_CLEAR_CODE) begin
      op_out = OP_WATCHDOG_CLEAR;
    end else if (instr_in == COMPUTED_CALL_CODE) begin
      op_out = OP_COMPUTED_CALL;
    end else if (instr_in[13:8] == INVERT_FILE_CODE) begin
      op_out = OP_INVERT_FILE;
    end else if (instr_in[13:8] == FILE_DECREMENT_CODE) begin
      op_out = OP_FILE_DECREMENT;
    end else if (instr_in[13:8] == DECREMENT_SKIP_CODE) begin
      op_out = OP_DECREMENT_SKIP;
    end else if (instr_in[13:7] == ZERO_FILE_CODE) begin
      op_out = OP_ZERO_FILE;
    end else if (instr_in[13:7] == ZERO_ACCUM_CODE) begin
      op_out = OP_ZERO_ACCUM;
    end
  end
endmodule

/* rtl/ccd_exec.sv */
module ccd_exec
  import ccd_pkg::*;
(
  input  wire logic        ref_clk_in,       // core clock, 40 MHz
  input  wire logic        rst_b_in,         // async reset, active low
  input  wire logic        clk_en_in,        // freezes all state when low
  input  wire logic        instr_valid_in,   // instruction offered
  input  wire logic [13:0] instr_in,         // instruction word
  input  wire logic [7:0]  file_data_in,     // contents of addressed register
  input  wire logic [7:0]  accum_in,         // current accumulator
  input  wire logic [14:0] pc_in,            // address of offered instruction
  input  wire logic [7:0]  high_latch_in,    // counter_high_latch contents
  output logic             ready_out,        // instruction may be offered
  output logic             file_we_out,      // file register write strobe
  output logic [6:0]       file_addr_out,    // file register address
  output logic [7:0]       file_wdata_out,   // file register data
  output logic             accum_we_out,     // accumulator write strobe
  output logic [7:0]       accum_wdata_out,  // accumulator data
  output logic             zero_we_out,      // zero flag write strobe
  output logic             zero_out,         // zero flag value
  output logic             push_out,         // stack_top push strobe
  output logic [14:0]      push_addr_out,    // return address pushed
  output logic             pc_load_out,      // program counter load strobe
  output logic [14:0]      pc_target_out,    // program counter load value
  output logic             skip_out,         // discard next fetched instruction
  output logic [7:0]       wdt_count_out,    // watchdog_counter value
  output logic             wdt_timeout_out,  // watchdog expiry pulse
  output logic             expiry_flag_out,  // watchdog_expiry_flag
  output logic             power_down_out    // power_down_flag
);
  ccd_op_t    op;
  logic       dest;
  logic [6:0] addr;
  ccd_state_t state_r, state_nxt;
  logic       ready_r, ready_nxt;
  logic       fwe_r, fwe_nxt, awe_r, awe_nxt, zwe_r, zwe_nxt, zv_r, zv_nxt;
  logic [6:0] faddr_r, faddr_nxt;
  logic [7:0] fdat_r, fdat_nxt, adat_r, adat_nxt, res;
  logic       push_r, push_nxt, load_r, load_nxt, skip_r, skip_nxt;
  logic [14:0] paddr_r, paddr_nxt, tgt_r, tgt_nxt;
  logic       take, wdt_clr, res_write;
  logic [7:0] presc_r, presc_nxt, wcnt_r, wcnt_nxt;
  logic       tmo_r, tmo_nxt, exp_r, exp_nxt, pd_r, pd_nxt;

  ccd_opdec u_dec (
    .instr_in (instr_in),
    .op_out   (op),
    .dest_out (dest),
    .addr_out (addr)
  );

  assign take = instr_valid_in && (state_r == ST_IDLE);

  always_comb begin
    state_nxt = state_r;
    fwe_nxt   = 1'b0;
    awe_nxt   = 1'b0;
    zwe_nxt   = 1'b0;
    zv_nxt    = zv_r;
    faddr_nxt = faddr_r;
    fdat_nxt  = fdat_r;
    adat_nxt  = adat_r;
    push_nxt  = 1'b0;
    load_nxt  = 1'b0;
    skip_nxt  = 1'b0;
    paddr_nxt = paddr_r;
    tgt_nxt   = tgt_r;
    wdt_clr   = 1'b0;
    res       = BYTE_ZERO;
    res_write = 1'b0;
    unique case (state_r)
      ST_IDLE: begin
        if (take) begin
          unique case (op)
            OP_WATCHDOG_CLEAR: wdt_clr = 1'b1;
            OP_COMPUTED_CALL: begin
              push_nxt  = 1'b1;
              paddr_nxt = pc_in + PC_ONE;
              // target captured now so a later accumulator change is harmless
              tgt_nxt   = {high_latch_in[LATH_W-1:0], accum_in};
              state_nxt = ST_CALL_LOAD;
            end
            OP_INVERT_FILE: begin
              res       = ~file_data_in;
              res_write = 1'b1;
            end
            OP_ZERO_FILE: begin
              fwe_nxt   = 1'b1;
              faddr_nxt = addr;
              fdat_nxt  = BYTE_ZERO;
              zwe_nxt   = 1'b1;
              zv_nxt    = 1'b1;
            end
            OP_ZERO_ACCUM: begin
              awe_nxt   = 1'b1;
              adat_nxt  = BYTE_ZERO;
              zwe_nxt   = 1'b1;
              zv_nxt    = 1'b1;
            end
            OP_FILE_DECREMENT, OP_DECREMENT_SKIP: begin
              res       = file_data_in - BYTE_ONE;
              res_write = 1'b1;
            end
            OP_NONE: ;
          endcase
          if (res_write) begin
            if (dest == DEST_ACCUM) begin
              awe_nxt  = 1'b1;
              adat_nxt = res;
            end else begin
              fwe_nxt   = 1'b1;
              faddr_nxt = addr;
              fdat_nxt  = res;
            end
            if (op != OP_DECREMENT_SKIP) begin
              zwe_nxt = 1'b1;
              zv_nxt  = (res == BYTE_ZERO);
            end else if (res == BYTE_ZERO) begin
              // discard next, spend a no-op cycle
              skip_nxt  = 1'b1;
              state_nxt = ST_SKIP_NOP;
            end
          end
        end
      end
      ST_CALL_LOAD: begin
        load_nxt  = 1'b1;
        state_nxt = ST_IDLE;
      end
      ST_SKIP_NOP: state_nxt = ST_IDLE;
    endcase
    ready_nxt = (state_nxt == ST_IDLE);
  end

  // watchdog: prescaler wraps advance the counter; counter wrap is a timeout
  always_comb begin
    presc_nxt = presc_r + BYTE_ONE;
    wcnt_nxt  = wcnt_r;
    tmo_nxt   = 1'b0;
    exp_nxt   = exp_r;
    pd_nxt    = pd_r;
    if (presc_r == BYTE_MAX) begin
      wcnt_nxt = wcnt_r + BYTE_ONE;
      if (wcnt_r == BYTE_MAX) begin
        tmo_nxt = 1'b1;
        exp_nxt = 1'b0;
      end
    end
    // clear placed last so it wins over a timeout in the same cycle
    if (wdt_clr) begin
      presc_nxt = BYTE_ZERO;
      wcnt_nxt  = BYTE_ZERO;
      tmo_nxt   = 1'b0;
      exp_nxt   = 1'b1;
      pd_nxt    = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_r <= ST_IDLE;
      ready_r <= 1'b1;
      fwe_r   <= 1'b0;
      awe_r   <= 1'b0;
      zwe_r   <= 1'b0;
      zv_r    <= 1'b0;
      faddr_r <= ADDR_ZERO;
      fdat_r  <= BYTE_ZERO;
      adat_r  <= BYTE_ZERO;
      push_r  <= 1'b0;
      load_r  <= 1'b0;
      skip_r  <= 1'b0;
      paddr_r <= PC_ZERO;
      tgt_r   <= PC_ZERO;
      presc_r <= BYTE_ZERO;
      wcnt_r  <= BYTE_ZERO;
      tmo_r   <= 1'b0;
      exp_r   <= EXPIRY_RST;
      pd_r    <= PDOWN_RST;
    end else if (clk_en_in) begin
      state_r <= state_nxt;
      ready_r <= ready_nxt;
      fwe_r   <= fwe_nxt;
      awe_r   <= awe_nxt;
      zwe_r   <= zwe_nxt;
      zv_r    <= zv_nxt;
      faddr_r <= faddr_nxt;
      fdat_r  <= fdat_nxt;
      adat_r  <= adat_nxt;
      push_r  <= push_nxt;
      load_r  <= load_nxt;
      skip_r  <= skip_nxt;
      paddr_r <= paddr_nxt;
      tgt_r   <= tgt_nxt;
      presc_r <= presc_nxt;
      wcnt_r  <= wcnt_nxt;
      tmo_r   <= tmo_nxt;
      exp_r   <= exp_nxt;
      pd_r    <= pd_nxt;
    end
  end

  assign ready_out       = ready_r;
  assign file_we_out     = fwe_r;
  assign file_addr_out   = faddr_r;
  assign file_wdata_out  = fdat_r;
  assign accum_we_out    = awe_r;
  assign accum_wdata_out = adat_r;
  assign zero_we_out     = zwe_r;
  assign zero_out        = zv_r;
  assign push_out        = push_r;
  assign push_addr_out   = paddr_r;
  assign pc_load_out     = load_r;
  assign pc_target_out   = tgt_r;
  assign skip_out        = skip_r;
  assign wdt_count_out   = wcnt_r;
  assign wdt_timeout_out = tmo_r;
  assign expiry_flag_out = exp_r;
  assign power_down_out  = pd_r;

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);

  chk_wdt_zeroed: assert property (clk_en_in && take && op == OP_WATCHDOG_CLEAR |=>
    wcnt_r == BYTE_ZERO && presc_r == BYTE_ZERO) else $error("watchdog not zeroed");
  chk_wdt_flags: assert property (clk_en_in && take && op == OP_WATCHDOG_CLEAR |=>
    expiry_flag_out && power_down_out) else $error("watchdog flags not set");
  chk_call_push: assert property (clk_en_in && take && op == OP_COMPUTED_CALL |=>
    push_out && push_addr_out == $past(pc_in) + PC_ONE) else $error("bad call push");
  chk_call_load: assert property (push_out && clk_en_in |=>
    pc_load_out && !push_out && pc_target_out == $past(pc_target_out))
    else $error("call load missing");
  chk_call_flags: assert property (clk_en_in && take && op == OP_COMPUTED_CALL |=>
    !zero_we_out && !ready_out) else $error("call touched flags");
  chk_inv_value: assert property (clk_en_in && take && op == OP_INVERT_FILE && dest |=>
    file_we_out && file_wdata_out == ~$past(file_data_in)) else $error("bad complement");
  chk_dest_accum: assert property (clk_en_in && take && !dest &&
    (op == OP_INVERT_FILE || op == OP_FILE_DECREMENT) |=> accum_we_out && !file_we_out)
    else $error("bad destination");
  chk_zero_file: assert property (clk_en_in && take && op == OP_ZERO_FILE |=>
    file_we_out && file_wdata_out == BYTE_ZERO && zero_we_out && zero_out)
    else $error("zero-file wrong");
  chk_zero_accum: assert property (clk_en_in && take && op == OP_ZERO_ACCUM |=>
    accum_we_out && accum_wdata_out == BYTE_ZERO && zero_out) else $error("zero-accum wrong");
  chk_dec_value: assert property (clk_en_in && take && op == OP_FILE_DECREMENT &&
    !dest |=> accum_wdata_out == $past(file_data_in) - BYTE_ONE && zero_we_out)
    else $error("bad decrement");
  chk_skip_nop: assert property (clk_en_in && take && op == OP_DECREMENT_SKIP &&
    file_data_in == BYTE_ONE |=> skip_out && !ready_out && !zero_we_out)
    else $error("skip not taken");
  chk_skip_zflag: assert property (clk_en_in && take && op == OP_DECREMENT_SKIP |=>
    !zero_we_out) else $error("skip changed zero flag");

  cov_call: cover property (push_out ##1 pc_load_out);
  cov_skip: cover property (skip_out);
  cov_wdt: cover property (clk_en_in && take && op == OP_WATCHDOG_CLEAR);
endmodule

/* tb/clear_complement_decrement_exec_bench.sv */
module clear_complement_decrement_exec_bench import ccd_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic fwe; logic [6:0] fa; logic [7:0] fd; logic awe; logic [7:0] ad; logic zwe;
    logic z; logic push; logic [14:0] pa; logic pcl; logic [14:0] pt; logic skip;
  } ccd_res_t;
  logic        ref_clk_in, rst_b_in, clk_en_in, instr_valid_in;
  logic [13:0] instr_in;
  logic [7:0]  file_data_in, accum_in, high_latch_in;
  logic [14:0] pc_in;
  logic        ready_out, file_we_out, accum_we_out, zero_we_out, zero_out, push_out;
  logic        pc_load_out, skip_out, wdt_timeout_out, expiry_flag_out, power_down_out;
  logic [6:0]  file_addr_out;
  logic [7:0]  file_wdata_out, accum_wdata_out, wdt_count_out;
  logic [14:0] push_addr_out, pc_target_out;
  ccd_res_t    exp_q[$];
  ccd_res_t    e_w;
  int          error_cnt, check_count, cyc, n;
  ccd_op_t     ops[7] = '{OP_INVERT_FILE, OP_FILE_DECREMENT, OP_DECREMENT_SKIP, OP_ZERO_FILE,
                          OP_ZERO_ACCUM, OP_COMPUTED_CALL, OP_NONE};
  logic [7:0]  vals[4] = '{8'h01, 8'h00, 8'hff, 8'h5a};

  ccd_exec i_dut (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .clk_en_in(clk_en_in),
    .instr_valid_in(instr_valid_in), .instr_in(instr_in), .file_data_in(file_data_in),
    .accum_in(accum_in), .pc_in(pc_in), .high_latch_in(high_latch_in), .ready_out(ready_out),
    .file_we_out(file_we_out), .file_addr_out(file_addr_out), .file_wdata_out(file_wdata_out),
    .accum_we_out(accum_we_out), .accum_wdata_out(accum_wdata_out), .zero_we_out(zero_we_out),
    .zero_out(zero_out), .push_out(push_out), .push_addr_out(push_addr_out),
    .pc_load_out(pc_load_out), .pc_target_out(pc_target_out), .skip_out(skip_out),
    .wdt_count_out(wdt_count_out), .wdt_timeout_out(wdt_timeout_out),
    .expiry_flag_out(expiry_flag_out), .power_down_out(power_down_out));

  initial begin
    ref_clk_in = 1'b0;
    forever #12.5 ref_clk_in = ~ref_clk_in;
  end

  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_res(input ccd_res_t got, input ccd_res_t exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick();
    @(posedge ref_clk_in);
    #2;
  endtask

  // offers one instruction and notes what must come out; valid stays up afterwards
  task automatic run_op(input ccd_op_t op, input logic d, input logic [7:0] f);
    logic [6:0]  ad;
    logic [7:0]  a, h, r;
    logic [13:0] ins;
    logic [14:0] p;
    ccd_res_t    e, e2;
    ad = 7'($urandom);
    a = 8'($urandom);
    h = 8'($urandom);
    p = 15'($urandom);
    e = '0;
    e2 = '0;
    r = (op == OP_INVERT_FILE) ? ~f : f - 8'h01;
    case (op)
      OP_INVERT_FILE:    ins = {INVERT_FILE_CODE, d, ad};
      OP_FILE_DECREMENT: ins = {FILE_DECREMENT_CODE, d, ad};
      OP_DECREMENT_SKIP: ins = {DECREMENT_SKIP_CODE, d, ad};
      OP_ZERO_FILE:      ins = {ZERO_FILE_CODE, ad};
      OP_ZERO_ACCUM:     ins = {ZERO_ACCUM_CODE, ad};
      OP_COMPUTED_CALL:  ins = COMPUTED_CALL_CODE;
      OP_WATCHDOG_CLEAR: ins = WATCHDOG_CLEAR_CODE;
      default:           ins = 14'h3fff;
    endcase
    if (op inside {OP_INVERT_FILE, OP_FILE_DECREMENT, OP_DECREMENT_SKIP}) begin
      e.fwe = d;
      e.awe = !d;
      e.fa = d ? ad : 7'h00;
      e.fd = d ? r : 8'h00;
      e.ad = d ? 8'h00 : r;
      e.zwe = (op != OP_DECREMENT_SKIP);
      e.z = e.zwe && (r == 8'h00);
      e.skip = (op == OP_DECREMENT_SKIP) && (r == 8'h00);
    end
    if (op == OP_ZERO_FILE) e = '{fwe: 1'b1, fa: ad, zwe: 1'b1, z: 1'b1, default: '0};
    if (op == OP_ZERO_ACCUM) e = '{awe: 1'b1, zwe: 1'b1, z: 1'b1, default: '0};
    if (op == OP_COMPUTED_CALL) begin
      e = '{push: 1'b1, pa: p + 15'h0001, default: '0};
      e2 = '{pcl: 1'b1, pt: {h[6:0], a}, default: '0};
    end
    // offers made while busy must be ignored, so the old word stays up meanwhile
    while (ready_out !== 1'b1) tick();
    if (e != '0) exp_q.push_back(e);
    if (e2 != '0) exp_q.push_back(e2);
    {instr_in, file_data_in, accum_in, pc_in, high_latch_in} = {ins, f, a, p, h};
    instr_valid_in = 1'b1;
    tick();
  endtask

  function automatic ccd_res_t obs_now();
    ccd_res_t o;
    o = '0;
    o.fwe = file_we_out;
    o.fa = file_we_out ? file_addr_out : 7'h00;
    o.fd = file_we_out ? file_wdata_out : 8'h00;
    o.awe = accum_we_out;
    o.ad = accum_we_out ? accum_wdata_out : 8'h00;
    o.zwe = zero_we_out;
    o.z = zero_we_out ? zero_out : 1'b0;
    o.push = push_out;
    o.pa = push_out ? push_addr_out : 15'h0000;
    o.pcl = pc_load_out;
    o.pt = pc_load_out ? pc_target_out : 15'h0000;
    o.skip = skip_out;
    return o;
  endfunction

  always @(posedge ref_clk_in) begin
    #1;
    if (rst_b_in && clk_en_in && (file_we_out | accum_we_out | zero_we_out | push_out
        | pc_load_out | skip_out)) begin
      e_w = (exp_q.size() > 0) ? exp_q.pop_front() : ccd_res_t'('0);
      cmp_res(obs_now(), e_w);
    end
  end

  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 80000) begin
      error_cnt++;
      stop_test();
    end
  end

  initial begin
    {rst_b_in, clk_en_in, instr_valid_in, instr_in} = {1'b0, 1'b1, 1'b0, 14'h0000};
    {file_data_in, accum_in, pc_in, high_latch_in} = '0;
    repeat (3) @(posedge ref_clk_in);
    #2;
    rst_b_in = 1'b1;
    // ready, expiry and power-down high, zero flag and watchdog count clear
    check_val({4'h0, ready_out, expiry_flag_out, power_down_out, zero_out, wdt_count_out},
              16'h0e00);
    void'($urandom(8));
    foreach (ops[k]) for (int j = 0; j < 8; j++) run_op(ops[k], j[0], vals[j/2]);
    repeat (40) run_op(ops[$urandom % 7], 1'($urandom), 8'($urandom));
    instr_valid_in = 1'b0;
    repeat (600) tick();
    run_op(OP_WATCHDOG_CLEAR, 1'b0, 8'h00);
    instr_valid_in = 1'b0;
    tick();
    check_val({wdt_count_out, expiry_flag_out, power_down_out}, 16'h0003);
    // frozen clock enable: the offer must wait until enable returns
    clk_en_in = 1'b0;
    run_op(OP_ZERO_ACCUM, 1'b0, 8'h00);
    repeat (3) tick();
    check_val(16'(exp_q.size()), 16'h0001);
    clk_en_in = 1'b1;
    tick();
    instr_valid_in = 1'b0;
    n = 0;
    while (wdt_timeout_out !== 1'b1 && n < 66000) begin
      tick();
      n++;
    end
    // counter plus prescaler wrap after 65536 enabled cycles
    check_val(16'(n >= 65530 && n <= 65538), 16'h0001);
    tick();
    check_val({expiry_flag_out, power_down_out}, 16'h0001);
    run_op(OP_WATCHDOG_CLEAR, 1'b0, 8'h00);
    instr_valid_in = 1'b0;
    tick();
    check_val({wdt_count_out, expiry_flag_out, power_down_out}, 16'h0003);
    repeat (3) tick();
    check_val(16'(exp_q.size()), 16'h0000);
    stop_test();
  end
endmodule
